// ---- common/port_ctrl_params.svh ----
// offsets, field positions, reset values for the port pin control block
// assumes an 8-bit i/o register space with a 6-bit address
`ifndef PORT_CTRL_PARAMS_SVH
`define PORT_CTRL_PARAMS_SVH

`define PE_PIN_READ_ADDR 6'h01
`define PE_DIR_ADDR 6'h02
`define PE_LATCH_ADDR 6'h03
`define PD_PIN_READ_ADDR 6'h10
`define PD_DIR_ADDR 6'h11
`define PD_LATCH_ADDR 6'h12
`define PC_LATCH_ADDR 6'h15

`define PORT_RESET_VAL 8'h00
`define UNMAPPED_READ_VAL 8'h00

`define PB_SS_BIT 0
`define PB_SCK_BIT 1
`define PB_MOSI_BIT 2
`define PB_MISO_BIT 3
`define PD_CAPTURE_BIT 4
`define PD_T1_BIT 6
`define PD_T2_BIT 7
`define PE_RX_BIT 0
`define PE_TX_BIT 1
`define PE_ACP_BIT 2
`define PE_ACN_BIT 3

`endif

// ---- common/port_ctrl_pkg.sv ----
// types shared by the port pin control block
// no assumptions beyond a systemverilog-2012 tool
package port_ctrl_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [5:0] io_addr_t;

  // gray order along off -> slave -> master
  typedef enum logic [1:0]
  {
    SPI_OFF = 2'b00,
    SPI_SLAVE = 2'b01,
    SPI_MASTER = 2'b11
  } spi_role_t;

endpackage : port_ctrl_pkg

// ---- rtl/pin_sync.sv ----
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to the core clock
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end
        else
        begin
          meta_ff[g] <= i_async[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_ff;

endmodule : pin_sync

// ---- rtl/multi_port_pin_control.sv ----
// pin control for ports b (spi override), c, d and e
// assumes i/o register strobes and spi/timer inputs are on I_CLK_SYS
`timescale 1ns/100ps
`include "port_ctrl_params.svh"
module multi_port_pin_control #(
  parameter int CAP_W = 16
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // i/o register access
  input wire port_ctrl_pkg::io_addr_t I_IO_ADDR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire port_ctrl_pkg::byte_t I_IO_WDATA,
  output port_ctrl_pkg::byte_t O_IO_RDATA,
  // spi control and port b bits 0-3
  input wire logic I_SPI_ENABLE,
  input wire logic I_SPI_MASTER,
  input wire logic [3:0] I_PORTB_DIR,
  input wire logic [3:0] I_PORTB_LATCH,
  input wire logic [3:0] I_PORTB_PIN,
  output logic [3:0] O_PORTB_DIR,
  output logic [3:0] O_PORTB_PULLUP,
  output logic [3:0] O_PORTB_PIN_SYNC,
  output logic O_SPI_SLAVE_SELECTED,
  // port c and external memory
  input wire logic I_XMEM_ACCESS,
  input wire port_ctrl_pkg::byte_t I_XMEM_ADDR_HI,
  output port_ctrl_pkg::byte_t O_PORT_C_OUTPUT_LATCH_OUT,
  // port d pins
  input wire port_ctrl_pkg::byte_t I_PORT_D_OUTPUT_LATCH_PIN,
  output port_ctrl_pkg::byte_t O_PORT_D_OUTPUT_LATCH_OUT,
  output port_ctrl_pkg::byte_t O_PORT_D_OUTPUT_LATCH_OE,
  output port_ctrl_pkg::byte_t O_PORT_D_OUTPUT_LATCH_PULLUP,
  // port e pins
  input wire port_ctrl_pkg::byte_t I_PORT_E_OUTPUT_LATCH_PIN,
  output port_ctrl_pkg::byte_t O_PORT_E_OUTPUT_LATCH_OUT,
  output port_ctrl_pkg::byte_t O_PORT_E_OUTPUT_LATCH_OE,
  output port_ctrl_pkg::byte_t O_PORT_E_OUTPUT_LATCH_PULLUP,
  // port e transmit override
  input wire logic I_TX_ALT_EN,
  input wire logic I_TX_ALT_DATA,
  // alternate functions
  output port_ctrl_pkg::byte_t O_EXT_IRQ_N,
  output logic O_TIMER_ONE_COUNT_IN,
  output logic O_TIMER_TWO_COUNT_IN,
  output logic O_PROG_SERIAL_IN,
  output logic O_COMPARATOR_POS_IN,
  output logic O_COMPARATOR_NEG_IN,
  // timer 1 capture
  input wire logic I_CAPTURE_RISING,
  input wire logic [CAP_W-1:0] I_TIMER1_COUNT,
  output logic [CAP_W-1:0] O_TIMER1_CAPTURE,
  output logic O_CAPTURE_EVENT
);
  import port_ctrl_pkg::*;

  byte_t pd_sync;
  byte_t pe_sync;
  logic [3:0] pb_sync;

  // pins are asynchronous, so every pin is synchronised before use
  pin_sync #(.WIDTH(8)) u_sync_d (
    .clk(I_CLK_SYS),
    .rst(I_RESET),
    .i_async(I_PORT_D_OUTPUT_LATCH_PIN),
    .o_sync(pd_sync)
  );
  pin_sync #(.WIDTH(8)) u_sync_e (
    .clk(I_CLK_SYS),
    .rst(I_RESET),
    .i_async(I_PORT_E_OUTPUT_LATCH_PIN),
    .o_sync(pe_sync)
  );
  pin_sync #(.WIDTH(4)) u_sync_b (
    .clk(I_CLK_SYS),
    .rst(I_RESET),
    .i_async(I_PORTB_PIN),
    .o_sync(pb_sync)
  );

  // register group
  byte_t pd_dir_ff, nxt_pd_dir;
  byte_t pd_latch_ff, nxt_pd_latch;
  byte_t pe_dir_ff, nxt_pe_dir;
  byte_t pe_latch_ff, nxt_pe_latch;
  byte_t pc_latch_ff, nxt_pc_latch;
  byte_t rdata_ff, nxt_rdata;

  always_comb
  begin
    nxt_pd_dir = pd_dir_ff;
    nxt_pd_latch = pd_latch_ff;
    nxt_pe_dir = pe_dir_ff;
    nxt_pe_latch = pe_latch_ff;
    nxt_pc_latch = pc_latch_ff;
    nxt_rdata = rdata_ff;
    // pin read addresses take no write effect
    if (I_IO_WR)
    begin
      if (I_IO_ADDR == `PD_DIR_ADDR)
        nxt_pd_dir = I_IO_WDATA;
      else if (I_IO_ADDR == `PD_LATCH_ADDR)
        nxt_pd_latch = I_IO_WDATA;
      else if (I_IO_ADDR == `PE_DIR_ADDR)
        nxt_pe_dir = I_IO_WDATA;
      else if (I_IO_ADDR == `PE_LATCH_ADDR)
        nxt_pe_latch = I_IO_WDATA;
      else if (I_IO_ADDR == `PC_LATCH_ADDR)
        nxt_pc_latch = I_IO_WDATA;
    end
    if (I_IO_RD)
    begin
      if (I_IO_ADDR == `PD_PIN_READ_ADDR)
        nxt_rdata = pd_sync;
      else if (I_IO_ADDR == `PD_DIR_ADDR)
        nxt_rdata = pd_dir_ff;
      else if (I_IO_ADDR == `PD_LATCH_ADDR)
        nxt_rdata = pd_latch_ff;
      else if (I_IO_ADDR == `PE_PIN_READ_ADDR)
        nxt_rdata = pe_sync;
      else if (I_IO_ADDR == `PE_DIR_ADDR)
        nxt_rdata = pe_dir_ff;
      else if (I_IO_ADDR == `PE_LATCH_ADDR)
        nxt_rdata = pe_latch_ff;
      else if (I_IO_ADDR == `PC_LATCH_ADDR)
        nxt_rdata = pc_latch_ff;
      else
        nxt_rdata = `UNMAPPED_READ_VAL;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      pd_dir_ff <= `PORT_RESET_VAL;
      pd_latch_ff <= `PORT_RESET_VAL;
      pe_dir_ff <= `PORT_RESET_VAL;
      pe_latch_ff <= `PORT_RESET_VAL;
      pc_latch_ff <= `PORT_RESET_VAL;
      rdata_ff <= `PORT_RESET_VAL;
    end
    else
    begin
      pd_dir_ff <= nxt_pd_dir;
      pd_latch_ff <= nxt_pd_latch;
      pe_dir_ff <= nxt_pe_dir;
      pe_latch_ff <= nxt_pe_latch;
      pc_latch_ff <= nxt_pc_latch;
      rdata_ff <= nxt_rdata;
    end
  end

  // pin drive group; outputs lag the registers by one cycle
  spi_role_t spi_role;
  logic [3:0] pb_dir_ff, nxt_pb_dir;
  logic [3:0] pb_pull_ff, nxt_pb_pull;
  logic ss_sel_ff, nxt_ss_sel;
  byte_t pc_out_ff, nxt_pc_out;
  byte_t pd_pull_ff, nxt_pd_pull;
  byte_t pe_out_ff, nxt_pe_out;
  byte_t pe_oe_ff, nxt_pe_oe;
  byte_t pe_pull_ff, nxt_pe_pull;

  always_comb
  begin
    spi_role = !I_SPI_ENABLE ? SPI_OFF : (I_SPI_MASTER ? SPI_MASTER : SPI_SLAVE);
    nxt_pb_dir = I_PORTB_DIR;
    case (spi_role)
      SPI_SLAVE:
      begin
        nxt_pb_dir[`PB_SS_BIT] = 1'b0;
        nxt_pb_dir[`PB_SCK_BIT] = 1'b0;
        nxt_pb_dir[`PB_MOSI_BIT] = 1'b0;
      end
      SPI_MASTER:
        nxt_pb_dir[`PB_MISO_BIT] = 1'b0;
      default: nxt_pb_dir = I_PORTB_DIR;
    endcase
    nxt_pb_pull = ~nxt_pb_dir & I_PORTB_LATCH;
    nxt_ss_sel = (spi_role == SPI_SLAVE) && !pb_sync[`PB_SS_BIT];
    nxt_pc_out = I_XMEM_ACCESS ? I_XMEM_ADDR_HI : pc_latch_ff;
    nxt_pd_pull = ~pd_dir_ff & pd_latch_ff;
    nxt_pe_out = pe_latch_ff;
    nxt_pe_oe = pe_dir_ff;
    // transmit takes the pin as an output while enabled
    if (I_TX_ALT_EN)
    begin
      nxt_pe_out[`PE_TX_BIT] = I_TX_ALT_DATA;
      nxt_pe_oe[`PE_TX_BIT] = 1'b1;
    end
    nxt_pe_pull = ~nxt_pe_oe & pe_latch_ff;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      pb_dir_ff <= 4'h0;
      pb_pull_ff <= 4'h0;
      ss_sel_ff <= 1'b0;
      pc_out_ff <= `PORT_RESET_VAL;
      pd_pull_ff <= `PORT_RESET_VAL;
      pe_out_ff <= `PORT_RESET_VAL;
      pe_oe_ff <= `PORT_RESET_VAL;
      pe_pull_ff <= `PORT_RESET_VAL;
    end
    else
    begin
      pb_dir_ff <= nxt_pb_dir;
      pb_pull_ff <= nxt_pb_pull;
      ss_sel_ff <= nxt_ss_sel;
      pc_out_ff <= nxt_pc_out;
      pd_pull_ff <= nxt_pd_pull;
      pe_out_ff <= nxt_pe_out;
      pe_oe_ff <= nxt_pe_oe;
      pe_pull_ff <= nxt_pe_pull;
    end
  end

  // capture group; the pin is used even if left as output, software's care
  logic cap_prev_ff, nxt_cap_prev;
  logic cap_evt_ff, nxt_cap_evt;
  logic [CAP_W-1:0] cap_ff, nxt_cap;
  logic cap_edge;

  always_comb
  begin
    nxt_cap_prev = pd_sync[`PD_CAPTURE_BIT];
    cap_edge = (pd_sync[`PD_CAPTURE_BIT] != cap_prev_ff) &&
      (pd_sync[`PD_CAPTURE_BIT] == I_CAPTURE_RISING);
    nxt_cap_evt = cap_edge;
    nxt_cap = cap_edge ? I_TIMER1_COUNT : cap_ff;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      cap_prev_ff <= 1'b0;
      cap_evt_ff <= 1'b0;
      cap_ff <= '0;
    end
    else
    begin
      cap_prev_ff <= nxt_cap_prev;
      cap_evt_ff <= nxt_cap_evt;
      cap_ff <= nxt_cap;
    end
  end

  // outputs
  assign O_IO_RDATA = rdata_ff;
  assign O_PORTB_DIR = pb_dir_ff;
  assign O_PORTB_PULLUP = pb_pull_ff;
  assign O_PORTB_PIN_SYNC = pb_sync;
  assign O_SPI_SLAVE_SELECTED = ss_sel_ff;
  assign O_PORT_C_OUTPUT_LATCH_OUT = pc_out_ff;
  assign O_PORT_D_OUTPUT_LATCH_OUT = pd_latch_ff;
  assign O_PORT_D_OUTPUT_LATCH_OE = pd_dir_ff;
  assign O_PORT_D_OUTPUT_LATCH_PULLUP = pd_pull_ff;
  assign O_PORT_E_OUTPUT_LATCH_OUT = pe_out_ff;
  assign O_PORT_E_OUTPUT_LATCH_OE = pe_oe_ff;
  assign O_PORT_E_OUTPUT_LATCH_PULLUP = pe_pull_ff;
  assign O_EXT_IRQ_N = {pe_sync[7:4], pd_sync[3:0]};
  assign O_TIMER_ONE_COUNT_IN = pd_sync[`PD_T1_BIT];
  assign O_TIMER_TWO_COUNT_IN = pd_sync[`PD_T2_BIT];
  assign O_PROG_SERIAL_IN = pe_sync[`PE_RX_BIT];
  assign O_COMPARATOR_POS_IN = pe_sync[`PE_ACP_BIT];
  assign O_COMPARATOR_NEG_IN = pe_sync[`PE_ACN_BIT];
  assign O_TIMER1_CAPTURE = cap_ff;
  assign O_CAPTURE_EVENT = cap_evt_ff;

  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  AST_PB_SLAVE_IN: assert property (
    I_SPI_ENABLE && !I_SPI_MASTER |=> O_PORTB_DIR[2:0] == 3'h0)
    else $error("slave spi left a port b pin as output");
  AST_PB_MASTER_DIR: assert property (
    I_SPI_ENABLE && I_SPI_MASTER |=> O_PORTB_DIR[2:0] == $past(I_PORTB_DIR[2:0]))
    else $error("master spi did not follow port b direction bits");
  AST_PB_MISO_IN: assert property (
    I_SPI_ENABLE && I_SPI_MASTER |=> !O_PORTB_DIR[3])
    else $error("master spi left data input as output");
  AST_PB_PULLUP: assert property (
    I_SPI_ENABLE && !I_SPI_MASTER |=> O_PORTB_PULLUP[2:0] == $past(I_PORTB_LATCH[2:0]))
    else $error("forced input pull-up does not follow latch");
  AST_SS_SELECT: assert property (
    I_SPI_ENABLE && !I_SPI_MASTER && !O_PORTB_PIN_SYNC[0] |=> O_SPI_SLAVE_SELECTED)
    else $error("slave not selected with select pin low");
  AST_PC_XMEM: assert property (
    I_XMEM_ACCESS |=> O_PORT_C_OUTPUT_LATCH_OUT == $past(I_XMEM_ADDR_HI))
    else $error("port c did not carry high address byte");
  AST_PD_DIR_WR: assert property (
    I_IO_WR && I_IO_ADDR == `PD_DIR_ADDR |=> O_PORT_D_OUTPUT_LATCH_OE == $past(I_IO_WDATA))
    else $error("port d direction write not applied");
  AST_PD_PIN_RO: assert property (
    I_IO_WR && I_IO_ADDR == `PD_PIN_READ_ADDR |=> $stable(O_PORT_D_OUTPUT_LATCH_OE) && $stable(O_PORT_D_OUTPUT_LATCH_OUT))
    else $error("write to port d pin read changed state");
  AST_PD_PULLUP: assert property (
    ##1 O_PORT_D_OUTPUT_LATCH_PULLUP == $past(~O_PORT_D_OUTPUT_LATCH_OE & O_PORT_D_OUTPUT_LATCH_OUT))
    else $error("port d pull-up wrong");
  AST_PD_PIN_READ: assert property (
    I_IO_RD && I_IO_ADDR == `PD_PIN_READ_ADDR |=> O_IO_RDATA == $past(pd_sync))
    else $error("port d pin read not synchronised level");
  AST_CAPTURE: assert property (
    O_CAPTURE_EVENT |-> O_TIMER1_CAPTURE == $past(I_TIMER1_COUNT))
    else $error("capture did not hold timer count");

endmodule : multi_port_pin_control

// ---- tb/pin_far_side.sv ----
// far-side pad model: resolves pad levels from device and outside drivers
// assumes one core clock; an undriven pad without pull-up toggles each cycle
`timescale 1ns/100ps
module pin_far_side #(
  parameter int WIDTH = 8
) (
  // clock
  input wire logic clk,
  // device side of the pads
  input wire logic [WIDTH-1:0] i_oe,
  input wire logic [WIDTH-1:0] i_out,
  input wire logic [WIDTH-1:0] i_pullup,
  // outside drivers
  input wire logic [WIDTH-1:0] i_ext_en,
  input wire logic [WIDTH-1:0] i_ext_val,
  output logic [WIDTH-1:0] o_pin
);
  logic [WIDTH-1:0] float_ff = '0;
  // a floating pad must never look like a stable level
  always @(posedge clk)
  begin
    float_ff <= ~float_ff;
  end
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      if (i_oe[i])
        o_pin[i] = i_out[i];
      else if (i_ext_en[i])
        o_pin[i] = i_ext_val[i];
      else if (i_pullup[i])
        o_pin[i] = 1'h1;
      else
        o_pin[i] = float_ff[i];
    end
  end
endmodule : pin_far_side

// ---- tb/multi_port_pin_control_tb_top.sv ----
// self-checking bench for the port pin control block
// assumes the far-side pad model and a 50 MHz core clock
`timescale 1ns/100ps
`include "port_ctrl_params.svh"
module multi_port_pin_control_tb_top;
  import port_ctrl_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  io_addr_t addr = '0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  byte_t wdata = '0;
  byte_t rdata;
  logic spi_en = 1'h0;
  logic spi_master = 1'h0;
  logic [3:0] b_dir = '0, b_latch = '0, b_ext = '0;
  logic [3:0] b_pin, b_dir_o, b_pull, b_sync;
  logic slave_sel;
  logic xmem = 1'h0;
  byte_t xaddr = '0;
  byte_t c_out;
  byte_t ext_en = 8'hff, d_ext = '0, e_ext = '0;
  byte_t d_pin, d_out, d_oe, d_pull, e_pin, e_out, e_oe, e_pull, irq_n;
  logic tx_en = 1'h0;
  logic tx_data = 1'h0;
  logic t1_in, t2_in, prog_in, cmp_p, cmp_n, cap_evt;
  logic cap_rise = 1'h0;
  logic [15:0] t1_count = '0;
  logic [15:0] cap_val;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  multi_port_pin_control #(.CAP_W(16)) u_multi_port_pin_control (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd),
    .I_IO_WDATA(wdata), .O_IO_RDATA(rdata), .I_SPI_ENABLE(spi_en),
    .I_SPI_MASTER(spi_master), .I_PORTB_DIR(b_dir), .I_PORTB_LATCH(b_latch),
    .I_PORTB_PIN(b_pin), .O_PORTB_DIR(b_dir_o), .O_PORTB_PULLUP(b_pull),
    .O_PORTB_PIN_SYNC(b_sync), .O_SPI_SLAVE_SELECTED(slave_sel), .I_XMEM_ACCESS(xmem),
    .I_XMEM_ADDR_HI(xaddr), .O_PORT_C_OUTPUT_LATCH_OUT(c_out), .I_PORT_D_OUTPUT_LATCH_PIN(d_pin), .O_PORT_D_OUTPUT_LATCH_OUT(d_out),
    .O_PORT_D_OUTPUT_LATCH_OE(d_oe), .O_PORT_D_OUTPUT_LATCH_PULLUP(d_pull), .I_PORT_E_OUTPUT_LATCH_PIN(e_pin), .O_PORT_E_OUTPUT_LATCH_OUT(e_out),
    .O_PORT_E_OUTPUT_LATCH_OE(e_oe), .O_PORT_E_OUTPUT_LATCH_PULLUP(e_pull), .I_TX_ALT_EN(tx_en),
    .I_TX_ALT_DATA(tx_data), .O_EXT_IRQ_N(irq_n), .O_TIMER_ONE_COUNT_IN(t1_in),
    .O_TIMER_TWO_COUNT_IN(t2_in), .O_PROG_SERIAL_IN(prog_in),
    .O_COMPARATOR_POS_IN(cmp_p), .O_COMPARATOR_NEG_IN(cmp_n), .I_CAPTURE_RISING(cap_rise),
    .I_TIMER1_COUNT(t1_count), .O_TIMER1_CAPTURE(cap_val), .O_CAPTURE_EVENT(cap_evt));
  pin_far_side #(.WIDTH(4)) u_pin_far_side_b (.clk(clk), .i_oe(b_dir_o), .i_out(b_latch),
    .i_pullup(b_pull), .i_ext_en(4'hf), .i_ext_val(b_ext), .o_pin(b_pin));
  pin_far_side #(.WIDTH(8)) u_pin_far_side_d (.clk(clk), .i_oe(d_oe), .i_out(d_out),
    .i_pullup(d_pull), .i_ext_en(ext_en), .i_ext_val(d_ext), .o_pin(d_pin));
  pin_far_side #(.WIDTH(8)) u_pin_far_side_e (.clk(clk), .i_oe(e_oe), .i_out(e_out),
    .i_pullup(e_pull), .i_ext_en(ext_en), .i_ext_val(e_ext), .o_pin(e_pin));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic io_write(input io_addr_t a, input byte_t v);
    @(posedge clk);
    #1 wr = 1'h1;
    addr = a;
    wdata = v;
    @(posedge clk);
    #1 wr = 1'h0;
  endtask : io_write
  task automatic io_read(input io_addr_t a, output byte_t v);
    @(posedge clk);
    #1 rd = 1'h1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'h0;
    v = rdata;
  endtask : io_read
  // sync chain plus registered outputs settle within four edges; spi slave select needs all four
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  function automatic byte_t exp_pin(byte_t dir, byte_t lat, byte_t ext);
    return (dir & lat) | (~dir & ext);
  endfunction : exp_pin
  function automatic logic [3:0] exp_bdir(logic en, logic m, logic [3:0] dir);
    if (!en)
      return dir;
    return m ? (dir & 4'h7) : (dir & 4'h8);
  endfunction : exp_bdir
  task automatic t_pins();
    byte_t dd, dl, ed, el, v;
    io_read(`PD_DIR_ADDR, v);
    check("reset_pd_dir", `PORT_RESET_VAL, v);
    check("reset_pe", 16'h0, {e_oe, e_out});
    check("reset_pc", `PORT_RESET_VAL, c_out);
    repeat (8)
    begin
      dd = byte_t'($urandom);
      dl = byte_t'($urandom);
      ed = byte_t'($urandom);
      el = byte_t'($urandom);
      d_ext = byte_t'($urandom);
      e_ext = byte_t'($urandom);
      io_write(`PD_DIR_ADDR, dd);
      io_write(`PD_LATCH_ADDR, dl);
      io_write(`PE_DIR_ADDR, ed);
      io_write(`PE_LATCH_ADDR, el);
      io_write(`PD_PIN_READ_ADDR, byte_t'($urandom));
      io_write(`PE_PIN_READ_ADDR, byte_t'($urandom));
      settle();
      check("pd_oe_out", {dd, dl}, {d_oe, d_out});
      check("pd_pull", ~dd & dl, d_pull);
      check("pe_pull", ~ed & el, e_pull);
      io_read(`PD_PIN_READ_ADDR, v);
      check("pd_pin", exp_pin(dd, dl, d_ext), v);
      io_read(`PE_PIN_READ_ADDR, v);
      check("pe_pin", exp_pin(ed, el, e_ext), v);
      io_read(`PD_LATCH_ADDR, v);
      check("pd_latch", dl, v);
      io_read(`PE_DIR_ADDR, v);
      check("pe_dir", ed, v);
      io_read(6'h3f, v);
      check("unmapped", `UNMAPPED_READ_VAL, v);
    end
    ext_en = 8'h00;
    io_write(`PD_DIR_ADDR, 8'h00);
    io_write(`PD_LATCH_ADDR, 8'hff);
    settle();
    io_read(`PD_PIN_READ_ADDR, v);
    check("pd_pulled_up", 8'hff, v);
    ext_en = 8'hff;
    $display("test pins done");
  endtask : t_pins
  task automatic t_port_c_output_latch();
    byte_t lat, v;
    repeat (8)
    begin
      lat = byte_t'($urandom);
      xaddr = byte_t'($urandom);
      xmem = 1'($urandom);
      io_write(`PC_LATCH_ADDR, lat);
      settle();
      check("pc_out", xmem ? xaddr : lat, c_out);
      io_read(`PC_LATCH_ADDR, v);
      check("pc_latch", lat, v);
    end
    xmem = 1'h0;
    $display("test port c done");
  endtask : t_port_c_output_latch
  task automatic t_spi();
    logic [3:0] ed;
    for (int m = 0; m < 3; m++)
    begin
      repeat (6)
      begin
        spi_en = (m != 0);
        spi_master = (m == 2);
        b_dir = 4'($urandom);
        b_latch = 4'($urandom);
        b_ext = 4'($urandom);
        settle();
        ed = exp_bdir(spi_en, spi_master, b_dir);
        check("pb_dir", ed, b_dir_o);
        check("pb_pull", ~ed & b_latch, b_pull);
        check("pb_sync", (ed & b_latch) | (~ed & b_ext), b_sync);
        check("slave_sel", spi_en & ~spi_master & ~b_ext[0], slave_sel);
      end
    end
    $display("test spi done");
  endtask : t_spi
  task automatic t_alt();
    io_write(`PD_DIR_ADDR, 8'h00);
    io_write(`PE_DIR_ADDR, 8'h00);
    io_write(`PE_LATCH_ADDR, 8'h00);
    repeat (8)
    begin
      d_ext = byte_t'($urandom);
      e_ext = byte_t'($urandom);
      tx_en = 1'($urandom);
      tx_data = 1'($urandom);
      settle();
      check("irq_n", {e_ext[7:4], d_ext[3:0]}, irq_n);
      check("alt_in", {d_ext[7:6], e_ext[0], e_ext[3:2]},
        {t2_in, t1_in, prog_in, cmp_n, cmp_p});
      check("tx_pin", {tx_en, tx_en & tx_data}, {e_oe[1], e_out[1]});
    end
    tx_en = 1'h0;
    $display("test alternate done");
  endtask : t_alt
  task automatic cap_edge(input logic pol, input logic lvl);
    int hits;
    logic [15:0] got;
    hits = 0;
    got = '0;
    cap_rise = pol;
    t1_count = 16'($urandom);
    d_ext[4] = lvl;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      if (cap_evt === 1'h1)
      begin
        hits++;
        got = cap_val;
      end
    end
    check("cap_hits", (pol == lvl) ? 16'h1 : 16'h0, hits[15:0]);
    if (pol == lvl)
      check("cap_val", t1_count, got);
  endtask : cap_edge
  task automatic t_cap();
    d_ext[4] = 1'h0;
    io_write(`PD_DIR_ADDR, 8'h00);
    settle();
    cap_edge(1'h1, 1'h1);
    cap_edge(1'h1, 1'h0);
    cap_edge(1'h0, 1'h1);
    cap_edge(1'h0, 1'h0);
    $display("test capture done");
  endtask : t_cap
  initial
  begin
    void'($urandom(97));
    repeat (5) @(posedge clk);
    #1 rst = 1'h0;
    t_pins();
    t_port_c_output_latch();
    t_spi();
    t_alt();
    t_cap();
    stop_test();
  end
endmodule : multi_port_pin_control_tb_top
